// ### cur_pkg.sv
// Constants and types for the cursor control register bank
package cur_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_IND_CTL = 8'h06;
  localparam logic [7:0] IDX_ALT_CTL = 8'h09;
  localparam logic [7:0] IDX_MISC = 8'h20;
  localparam logic [7:0] IDX_RAM_LO = 8'h21;
  localparam logic [7:0] IDX_STATUS = 8'h22;
  localparam logic [7:0] ADR_IND_CTL = IDX_IND_CTL << 2;
  localparam logic [7:0] ADR_ALT_CTL = IDX_ALT_CTL << 2;
  localparam logic [7:0] ADR_MISC = IDX_MISC << 2;
  localparam logic [7:0] ADR_RAM_LO = IDX_RAM_LO << 2;
  localparam logic [7:0] ADR_STATUS = IDX_STATUS << 2;
  // Reset values
  localparam logic [7:0] RST_IND_CTL = 8'h00;
  localparam logic [1:0] RST_ALT_MODE = 2'h0;
  localparam logic RST_PWDN = 1'b0;
  localparam logic [7:0] RST_RAM_LO = 8'h00;
  // Field positions in the indexed control register
  localparam int BIT_SRC = 7;
  localparam int BIT_INV = 6;
  localparam int BIT_ILACE = 5;
  localparam int BIT_VLEN = 4;
  localparam int BIT_A9 = 3;
  localparam int BIT_A8 = 2;
  localparam int BIT_MODE_HI = 1;
  localparam int BIT_MODE_LO = 0;
  // Field position in the misc register
  localparam int BIT_PWDN = 0;
  // Status register fields
  localparam int ST_MODE_LO = 0;
  localparam int ST_FIELD = 2;
  localparam int ST_VBLANK = 3;
  localparam int ST_ILACE = 4;
  // Vertical blank detection lengths in dot clocks
  localparam logic [12:0] VB_LEN_SHORT = 13'h0800;
  localparam logic [12:0] VB_LEN_LONG = 13'h1000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Cursor display formats
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_THREE_COLOR = 2'h1,
    MODE_HW_FORMAT = 2'h2,
    MODE_WINDOWING = 2'h3
  } cur_mode_type;
endpackage

// ### cur_vblank_det.sv
// Vertical blank detector working from the blank signal alone
`timescale 1ns/1ps
`default_nettype none
module cur_vblank_det (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic blank_sync,
  input wire logic long_sel,
  output logic vblank_start,
  output logic in_vblank
);
  logic blank_prev_reg; // Previous blank for edge detect
  logic [12:0] cnt_reg; // Dot clocks since last blank rise
  logic [12:0] limit; // Selected detection length
  logic rise; // Rising edge of blank
  logic vb_start_reg;
  logic in_vb_reg;

  assign limit = long_sel ? cur_pkg::VB_LEN_LONG : cur_pkg::VB_LEN_SHORT;
  assign rise = blank_sync && !blank_prev_reg;
  assign vblank_start = vb_start_reg;
  assign in_vblank = in_vb_reg;

  // Edge history
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      blank_prev_reg <= 1'b0;
    end else begin
      blank_prev_reg <= blank_sync;
    end
  end

  // Count, saturating so one long gap fires only once
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_reg <= 13'h0000;
    end else if (rise) begin
      cnt_reg <= 13'h0000;
    end else if (cnt_reg < limit) begin
      cnt_reg <= cnt_reg + 13'h0001;
    end
  end

  // Declare vertical blank on reaching the length
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vb_start_reg <= 1'b0;
      in_vb_reg <= 1'b0;
    end else begin
      vb_start_reg <= !rise && (cnt_reg == limit - 13'h0001);
      if (rise) begin
        in_vb_reg <= 1'b0;
      end else if (cnt_reg == limit - 13'h0001) begin
        in_vb_reg <= 1'b1;
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_no_early_vb: assert property (rise |=> !vb_start_reg [*8])
    else $error("vblank declared right after a blank edge");
  a_vb_needs_gap: assert property (vb_start_reg |-> !$past(rise))
    else $error("vblank declared on a blank edge");
endmodule
`default_nettype wire

// ### cur_ctl_top.sv
// Cursor control register bank with AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module cur_ctl_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic blank_pin,
  input wire logic odd_even_pin,
  output logic dac_power_down,
  output logic [1:0] cursor_mode,
  output logic [9:0] cursor_ram_addr,
  output logic cursor_field,
  output logic interlace_en,
  output logic vblank_start
);
  // Bus handshake state
  logic awready_reg; // Address slot free
  logic wready_reg; // Data slot free
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [7:0] aw_addr_reg; // Held write address
  logic [7:0] w_data_reg; // Held write data, low lane
  logic w_strb_reg; // Held lane 0 strobe
  logic do_write; // Both halves present, no response pending
  // Software registers
  logic [7:0] ind_ctl_reg; // Indexed cursor control
  logic [1:0] alt_mode_reg; // Alternate mode field only
  logic pwdn_reg; // Converter power-down
  logic [7:0] ram_lo_reg; // Cursor RAM address low byte
  // Pin synchronisers
  logic blank_s1_reg;
  logic blank_s2_reg;
  logic odd_s1_reg;
  logic odd_s2_reg;
  // Output registers; mode, invert and interlace latched per frame, the rest every cycle
  logic [1:0] mode_reg;
  logic inv_act_reg; // Invert in force this frame
  logic ilace_reg;
  logic field_reg;
  logic [9:0] ram_addr_reg;
  logic pwdn_out_reg;
  logic vblank_start_reg; // Port copy of the detector pulse
  logic [1:0] mode_sel; // Mode chosen by source bit
  logic vb_start;
  logic in_vb;

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign dac_power_down = pwdn_out_reg;
  assign cursor_mode = mode_reg;
  assign cursor_ram_addr = ram_addr_reg;
  assign cursor_field = field_reg;
  assign interlace_en = ilace_reg;
  assign vblank_start = vblank_start_reg;
  assign do_write = !awready_reg && !wready_reg && !bvalid_reg;

  // Write address channel; slot reopens when the response is taken
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      awready_reg <= 1'b1;
      aw_addr_reg <= 8'h00;
    end else if (awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      aw_addr_reg <= awaddr;
    end else if (bvalid_reg && bready) begin
      awready_reg <= 1'b1;
    end
  end

  // Write data channel, independent of address order
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wready_reg <= 1'b1;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
    end else if (wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      w_data_reg <= wdata[7:0];
      w_strb_reg <= wstrb[0];
    end else if (bvalid_reg && bready) begin
      wready_reg <= 1'b1;
    end
  end

  // Write response; unmapped or read-only addresses answer SLVERR
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= cur_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      unique case (aw_addr_reg)
        cur_pkg::ADR_IND_CTL, cur_pkg::ADR_ALT_CTL,
        cur_pkg::ADR_MISC, cur_pkg::ADR_RAM_LO: begin
          bresp_reg <= cur_pkg::RESP_OKAY;
        end
        default: begin
          bresp_reg <= cur_pkg::RESP_SLVERR;
        end
      endcase
    end else if (bvalid_reg && bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Register file; only lane 0 carries the 8-bit registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ind_ctl_reg <= cur_pkg::RST_IND_CTL;
      alt_mode_reg <= cur_pkg::RST_ALT_MODE;
      pwdn_reg <= cur_pkg::RST_PWDN;
      ram_lo_reg <= cur_pkg::RST_RAM_LO;
    end else if (do_write && w_strb_reg) begin
      unique case (aw_addr_reg)
        cur_pkg::ADR_IND_CTL: begin
          ind_ctl_reg <= w_data_reg;
        end
        cur_pkg::ADR_ALT_CTL: begin
          alt_mode_reg <= w_data_reg[1:0];
        end
        cur_pkg::ADR_MISC: begin
          pwdn_reg <= w_data_reg[cur_pkg::BIT_PWDN];
        end
        cur_pkg::ADR_RAM_LO: begin
          ram_lo_reg <= w_data_reg;
        end
        default: begin
        end
      endcase
    end
  end

  // Read channel; answer one cycle after the address is taken
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= cur_pkg::RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= cur_pkg::RESP_OKAY;
      unique case (araddr)
        cur_pkg::ADR_IND_CTL: begin
          rdata_reg[7:0] <= ind_ctl_reg;
        end
        cur_pkg::ADR_ALT_CTL: begin
          rdata_reg[1:0] <= alt_mode_reg;
        end
        cur_pkg::ADR_MISC: begin
          rdata_reg[cur_pkg::BIT_PWDN] <= pwdn_reg;
        end
        cur_pkg::ADR_RAM_LO: begin
          rdata_reg[7:0] <= ram_lo_reg;
        end
        cur_pkg::ADR_STATUS: begin
          rdata_reg[cur_pkg::ST_MODE_LO +: 2] <= mode_reg;
          rdata_reg[cur_pkg::ST_FIELD] <= field_reg;
          rdata_reg[cur_pkg::ST_VBLANK] <= in_vb;
          rdata_reg[cur_pkg::ST_ILACE] <= ilace_reg;
        end
        default: begin
          rresp_reg <= cur_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Two-flop synchronisers for the video pins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      blank_s1_reg <= 1'b0;
      blank_s2_reg <= 1'b0;
      odd_s1_reg <= 1'b0;
      odd_s2_reg <= 1'b0;
    end else begin
      blank_s1_reg <= blank_pin;
      blank_s2_reg <= blank_s1_reg;
      odd_s1_reg <= odd_even_pin;
      odd_s2_reg <= odd_s1_reg;
    end
  end

  // Vertical blank marks the frame boundary
  cur_vblank_det u_vb (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .blank_sync(blank_s2_reg),
    .long_sel(ind_ctl_reg[cur_pkg::BIT_VLEN]),
    .vblank_start(vb_start),
    .in_vblank(in_vb)
  );

  // Source select between indexed and alternate mode
  assign mode_sel = ind_ctl_reg[cur_pkg::BIT_SRC] ? alt_mode_reg :
    ind_ctl_reg[cur_pkg::BIT_MODE_HI:cur_pkg::BIT_MODE_LO];

  // Display settings switch only at vblank so a frame never tears
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_reg <= cur_pkg::MODE_OFF;
      inv_act_reg <= 1'b0;
      ilace_reg <= 1'b0;
    end else if (vb_start) begin
      mode_reg <= mode_sel;
      inv_act_reg <= ind_ctl_reg[cur_pkg::BIT_INV];
      ilace_reg <= ind_ctl_reg[cur_pkg::BIT_ILACE];
    end
  end

  // Field indicator; held low when interlace is off
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      field_reg <= 1'b0;
    end else begin
      field_reg <= ilace_reg && (odd_s2_reg ^ inv_act_reg);
    end
  end

  // RAM address and power-down apply at once
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ram_addr_reg <= 10'h000;
      pwdn_out_reg <= cur_pkg::RST_PWDN;
      vblank_start_reg <= 1'b0;
    end else begin
      ram_addr_reg <= {ind_ctl_reg[cur_pkg::BIT_A9],
                       ind_ctl_reg[cur_pkg::BIT_A8], ram_lo_reg};
      pwdn_out_reg <= pwdn_reg;
      vblank_start_reg <= vb_start;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_pwdn_follow: assert property (
    (do_write && w_strb_reg && aw_addr_reg == cur_pkg::ADR_MISC)
    |-> ##2 (dac_power_down == $past(w_data_reg[cur_pkg::BIT_PWDN], 2)))
    else $error("power-down output did not follow write");
  a_ind_rdback: assert property (
    (arvalid && arready_reg && araddr == cur_pkg::ADR_IND_CTL)
    |=> rvalid_reg && rresp_reg == cur_pkg::RESP_OKAY
        && rdata_reg == {24'h000000, $past(ind_ctl_reg)})
    else $error("indexed control readback wrong");
  a_mode_source: assert property (
    vb_start |=> cursor_mode == ($past(ind_ctl_reg[cur_pkg::BIT_SRC])
      ? $past(alt_mode_reg) : $past(ind_ctl_reg[1:0])))
    else $error("cursor mode from wrong source");
  a_field_sense: assert property (
    (ilace_reg && $stable(ilace_reg))
    |=> cursor_field == ($past(odd_s2_reg) ^ $past(inv_act_reg)))
    else $error("field polarity wrong");
  a_ilace_off: assert property (!ilace_reg |=> !cursor_field)
    else $error("field toggles with interlace off");
  a_ram_addr: assert property (
    ##1 cursor_ram_addr == {$past(ind_ctl_reg[3:2]), $past(ram_lo_reg)})
    else $error("cursor RAM address wrong");
  a_alt_rsvd: assert property (
    (arvalid && arready_reg && araddr == cur_pkg::ADR_ALT_CTL)
    |=> rdata_reg[31:2] == 30'h00000000)
    else $error("alternate reserved bits not zero");
  a_mode_frame: assert property (!$past(vb_start) |-> $stable(mode_reg))
    else $error("mode changed outside vblank");
  a_bad_write: assert property (
    (do_write && aw_addr_reg == cur_pkg::ADR_STATUS)
    |=> bvalid_reg && bresp_reg == cur_pkg::RESP_SLVERR)
    else $error("write to status not refused");

  c_vblank: cover property (vb_start);
  c_win_mode: cover property (mode_reg == cur_pkg::MODE_WINDOWING);
  c_alt_src: cover property (vb_start && ind_ctl_reg[cur_pkg::BIT_SRC]);
  c_ilace: cover property (ilace_reg && cursor_field);
endmodule
`default_nettype wire

// ### test_cur_ctl_top.sv
// Self-checking bench for the cursor control register bank
`timescale 1ns/1ps
`default_nettype none
module test_cur_ctl_top;
  // Clock, reset and bus signals
  logic core_clk, rst_n;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, cursor_mode, resp;
  // Video side
  logic blank_pin, odd_even_pin, dac_power_down, cursor_field, interlace_en, vblank_start;
  logic [9:0] cursor_ram_addr;
  int miscompares, checked;
  localparam logic [7:0] ADR_CLK_SEL = 8'h68; // Clock selection slot, owned elsewhere
  // One access: address, write word, strobes, then expected answers
  typedef struct {
    logic [7:0] addr;
    logic [31:0] wd;
    logic [3:0] strb;
    logic [1:0] bexp;
    logic [31:0] rexp;
    logic [1:0] rrexp;
  } cur_row_type;
  // Second indexed write has strobe 0, so the first value must survive
  cur_row_type rows [6] = '{
    '{cur_pkg::ADR_IND_CTL, 32'h0000_005a, 4'h1, 2'h0, 32'h0000_005a, 2'h0},
    '{cur_pkg::ADR_IND_CTL, 32'h0000_00a5, 4'h0, 2'h0, 32'h0000_005a, 2'h0},
    '{cur_pkg::ADR_ALT_CTL, 32'hffff_ffff, 4'hf, 2'h0, 32'h0000_0003, 2'h0},
    '{cur_pkg::ADR_MISC, 32'h0000_0001, 4'h1, 2'h0, 32'h0000_0001, 2'h0},
    '{cur_pkg::ADR_RAM_LO, 32'h0000_00c3, 4'h1, 2'h0, 32'h0000_00c3, 2'h0},
    '{8'hfc, 32'h0000_0077, 4'h1, 2'h2, 32'h0000_0000, 2'h2}
  };

  cur_ctl_top u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .blank_pin(blank_pin), .odd_even_pin(odd_even_pin), .dac_power_down(dac_power_down),
    .cursor_mode(cursor_mode), .cursor_ram_addr(cursor_ram_addr),
    .cursor_field(cursor_field), .interlace_en(interlace_en), .vblank_start(vblank_start)
  );

  // 40 MHz dot clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Single exit point with the verdict
  task automatic complete_run();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Word compare, four-state exact
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Response code compare
  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    check_word({30'h0, got}, {30'h0, exp});
  endtask

  // A hang counts against the run
  task automatic give_up();
    miscompares++;
    $display("timeout t=%0t", $time);
    complete_run();
  endtask

  // Write: AW and W offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    b_hs = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Ready is registered, so its value mid-cycle is what the next edge sees
    while (!b_hs && n < 100) begin
      @(negedge core_clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid && bready;
      r = bresp;
      @(posedge core_clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
      n++;
    end
    if (!b_hs) give_up();
    #1;
  endtask

  // Read: address held until taken, rready held until rvalid seen
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    r_hs = 1'b0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hs && n < 100) begin
      @(negedge core_clk);
      ar_hs = arvalid && arready;
      r_hs = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) rready <= 1'b0;
      n++;
    end
    if (!r_hs) give_up();
    #1;
  endtask

  // Reset for six cycles, then defaults at the ports and in the registers
  task automatic do_reset();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    check_word({22'h0, cursor_ram_addr}, 32'h0);
    check_word({29'h0, dac_power_down, cursor_mode}, 32'h0);
    check_word({30'h0, cursor_field, interlace_en}, 32'h0);
    axi_read(cur_pkg::ADR_IND_CTL, rd, resp);
    check_word(rd, 32'h0);
    axi_read(cur_pkg::ADR_ALT_CTL, rd, resp);
    check_word(rd, 32'h0);
  endtask

  // One blank pulse, then a quiet gap until the detector fires
  task automatic vblank(input int lim);
    int n;
    @(posedge core_clk);
    blank_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    blank_pin <= 1'b0;
    n = 4;
    while (vblank_start !== 1'b1 && n < 5000) begin
      @(posedge core_clk);
      n++;
      #1;
    end
    if (n >= 5000) give_up();
    // Pipeline adds a few edges beyond the count itself
    check_word((n >= lim && n <= lim + 6) ? 32'h1 : 32'h0, 32'h1);
  endtask

  // Field and interlace outputs a few edges after the pins settle
  task automatic field_check(input logic [31:0] exp);
    repeat (4) @(posedge core_clk);
    #1;
    check_word({30'h0, cursor_field, interlace_en}, exp);
  endtask

  initial begin
    rst_n = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    blank_pin = 1'b0;
    odd_even_pin = 1'b0;
    miscompares = 0;
    checked = 0;
    do_reset();
    // Ordinary accesses from the table
    foreach (rows[i]) begin
      axi_write(rows[i].addr, rows[i].wd, rows[i].strb, resp);
      check_resp(resp, rows[i].bexp);
      axi_read(rows[i].addr, rd, resp);
      check_word(rd, rows[i].rexp);
      check_resp(resp, rows[i].rrexp);
    end
    // Immediate fields: power-down and RAM address high bits
    check_word({31'h0, dac_power_down}, 32'h1);
    check_word({22'h0, cursor_ram_addr}, 32'h2c3);
    // Mode waits for the next frame; bit 4 picked the long gap
    check_word({30'h0, cursor_mode}, 32'h0);
    vblank(4096);
    check_word({30'h0, cursor_mode}, 32'h2);
    axi_write(cur_pkg::ADR_MISC, 32'h0, 4'h1, resp);
    check_word({31'h0, dac_power_down}, 32'h0);
    // Every mode code, each held off until the short gap ends
    for (int m = 0; m < 4; m++) begin
      axi_write(cur_pkg::ADR_IND_CTL, 32'((m + 3) % 4), 4'h1, resp);
      check_word({30'h0, cursor_mode}, 32'((m + 2) % 4));
      vblank(2048);
      check_word({30'h0, cursor_mode}, 32'((m + 3) % 4));
    end
    // Source select: alternate register wins while bit 7 is set
    axi_write(cur_pkg::ADR_ALT_CTL, 32'h1, 4'h1, resp);
    axi_write(cur_pkg::ADR_IND_CTL, 32'h83, 4'h1, resp);
    vblank(2048);
    check_word({30'h0, cursor_mode}, 32'h1);
    axi_write(cur_pkg::ADR_IND_CTL, 32'h03, 4'h1, resp);
    vblank(2048);
    check_word({30'h0, cursor_mode}, 32'h3);
    // Interlace on, normal sense: odd field then even field
    @(posedge core_clk);
    odd_even_pin <= 1'b1;
    axi_write(cur_pkg::ADR_IND_CTL, 32'h20, 4'h1, resp);
    vblank(2048);
    field_check(32'h3);
    @(posedge core_clk);
    odd_even_pin <= 1'b0;
    field_check(32'h1);
    // Inverted sense flips the even field to 1
    axi_write(cur_pkg::ADR_IND_CTL, 32'h60, 4'h1, resp);
    vblank(2048);
    field_check(32'h3);
    // Status is read-only: write refused, then frame state read back
    axi_write(cur_pkg::ADR_STATUS, 32'h0000_001f, 4'h1, resp);
    check_resp(resp, cur_pkg::RESP_SLVERR);
    axi_read(cur_pkg::ADR_STATUS, rd, resp);
    check_word(rd, 32'h0000_001c);
    // Interlace off forces the field low despite the invert bit
    axi_write(cur_pkg::ADR_IND_CTL, 32'h40, 4'h1, resp);
    vblank(2048);
    field_check(32'h0);
    // Clock stop code goes to a slot outside this bank, so it is refused
    axi_write(ADR_CLK_SEL, 32'h0000_0006, 4'h1, resp);
    check_resp(resp, cur_pkg::RESP_SLVERR);
    // Reset again in mid-run
    do_reset();
    complete_run();
  end
endmodule
`default_nettype wire
